/* File: inc/rcr_defs.vh */
// Constants for the reset cause resolver
`ifndef RCR_DEFS_VH
`define RCR_DEFS_VH

`define RCR_CTRL_PORT_ADDR 16'h0cf9
`define RCR_CTRL_RESET_VAL 8'h00
`define RCR_CTRL_STORE_MASK 8'h0a
`define RCR_CTRL_PCYCLE_BIT 3
`define RCR_CMD_HOST_RESET 8'h06
`define RCR_CMD_PCYCLE_RESET 8'h0e

`define RCR_SLEEP_S0 3'h0
`define RCR_SLEEP_S4 3'h4
`define RCR_SLEEP_S5 3'h5

`define RCR_OUT_HOST 2'h0
`define RCR_OUT_PCYCLE 2'h1
`define RCR_OUT_S5 2'h2
`define RCR_OUT_GLOBAL 2'h3

`define RCR_CLK_HZ 50000000
`define RCR_TIMEOUT_SEC 4
// Four seconds of the 50 MHz clock, sized to the 28-bit counters
`define RCR_TIMEOUT_CYCLES 28'hbeb_c200
`define RCR_OVERRIDE_SEC 4
`define RCR_OVERRIDE_CYCLES 28'hbeb_c200
`define RCR_GLOBAL_HOLD_CYCLES 8'h10

`define RCR_SYNC_INIT 5'h1c

`endif

/* File: design/rcr_pin_sync.v */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module rcr_pin_sync #(
    parameter [4:0] INIT = 5'h00
) (
    input wire clk_in,
    input wire reset_in,
    input wire [4:0] pins_in,
    output reg [4:0] pins_out
);
    reg [4:0] stage1;
    reg [4:0] stage2;
    reg [4:0] stage3;

    always @(posedge clk_in) begin
        if (reset_in) begin
            stage1 <= INIT;
            stage2 <= INIT;
            stage3 <= INIT;
            pins_out <= INIT;
        end else begin
            stage1 <= pins_in;
            stage2 <= stage1;
            stage3 <= stage2;
            // A bit moves only once the last two stages agree
            pins_out <= (~(stage2 ^ stage3) & stage3) | ((stage2 ^ stage3) & pins_out);
        end
    end
endmodule
`default_nettype wire

/* File: design/rcr_timer.v */
// Saturating run-time counter with expiry flag
`timescale 1ns/1ps
`default_nettype none
module rcr_timer #(
    parameter [27:0] LIMIT = 28'h000_0001
) (
    input wire clk_in,
    input wire reset_in,
    input wire run_in,
    output reg expired_out
);
    reg [27:0] count;

    always @(posedge clk_in) begin
        if (reset_in || !run_in) begin
            count <= 28'h000_0000;
            expired_out <= 1'b0;
        end else begin
            if (count != LIMIT) begin
                count <= count + 28'h000_0001;
            end
            expired_out <= (count == LIMIT - 28'h000_0001) || (count == LIMIT);
        end
    end
endmodule
`default_nettype wire

/* File: design/rcr_reset_cause_resolver.v */
// Reset cause resolver: maps reset triggers to reset types and runs the sequence
`timescale 1ns/1ps
`default_nettype none
`include "rcr_defs.vh"
module rcr_reset_cause_resolver #(
    parameter [27:0] TIMEOUT_CYCLES = `RCR_TIMEOUT_CYCLES,
    parameter [27:0] OVERRIDE_CYCLES = `RCR_OVERRIDE_CYCLES
) (
    input wire clk_in,
    input wire reset_in,
    input wire [15:0] io_addr_in,
    input wire io_write_in,
    input wire io_read_in,
    input wire [7:0] io_wdata_in,
    output reg [7:0] io_rdata_out,
    input wire global_reset_select_in,
    input wire global_escalation_enable_in,
    input wire system_reset_button_n_in,
    input wire platform_power_good_in,
    input wire system_power_good_in,
    input wire thermal_trip_n_in,
    input wire power_button_n_in,
    input wire platform_power_good_stuck_in,
    input wire smbus_reset_req_in,
    input wire smbus_reset_pcycle_in,
    input wire smbus_power_down_in,
    input wire os_watchdog_second_expiry_in,
    input wire thermal_sensor_catastrophic_in,
    input wire shutdown_cycle_in,
    input wire mgmt_host_reset_in,
    input wire mgmt_host_reset_pcycle_in,
    input wire mgmt_power_button_override_in,
    input wire mgmt_global_reset_in,
    input wire mgmt_host_reset_power_down_in,
    input wire mgmt_watchdog_timeout_in,
    input wire mgmt_uncorrectable_error_in,
    input wire pm_watchdog_timeout_in,
    input wire [2:0] sleep_state_in,
    input wire sleep_software_entered_in,
    input wire wake_event_in,
    input wire reset_ack_in,
    input wire platform_reset_done_in,
    output reg platform_reset_n_out,
    output reg reset_warn_out,
    output reg power_cycle_out,
    output reg global_reset_out,
    output reg sleep_wells_off_out,
    output reg host_held_down_out,
    output reg reset_start_out,
    output reg [1:0] reset_type_out,
    output wire busy_out
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_WARN = 3'h1;
    localparam [2:0] ST_RESET = 3'h2;
    localparam [2:0] ST_WAKE = 3'h3;
    localparam [2:0] ST_GLOBAL = 3'h4;

    reg [7:0] ctrl_port;
    reg [2:0] state;
    reg [2:0] prev_state;
    reg [2:0] next_state;
    reg [4:0] pins_prev;
    reg pcycle_flag;
    reg next_pcycle_flag;
    reg wake_hold_flag;
    reg next_wake_hold_flag;
    reg override_prev;
    reg [7:0] hold_count;
    wire [4:0] pins_sync;
    wire [4:0] pins_fall;
    wire seq_expired;
    wire override_expired;
    wire seq_run;

    // Most severe pending outcome wins
    function [1:0] rcr_resolve;
        input req_global;
        input req_s5;
        input req_pcycle;
        begin
            if (req_global) begin
                rcr_resolve = `RCR_OUT_GLOBAL;
            end else if (req_s5) begin
                rcr_resolve = `RCR_OUT_S5;
            end else if (req_pcycle) begin
                rcr_resolve = `RCR_OUT_PCYCLE;
            end else begin
                rcr_resolve = `RCR_OUT_HOST;
            end
        end
    endfunction

    // Bit order: power button, thermal trip, reset button, system pg, platform pg
    rcr_pin_sync #(
        .INIT(`RCR_SYNC_INIT)
    ) u_sync (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .pins_in({power_button_n_in, thermal_trip_n_in, system_reset_button_n_in,
                  system_power_good_in, platform_power_good_in}),
        .pins_out(pins_sync)
    );

    assign pins_fall = pins_prev & ~pins_sync;

    rcr_timer #(
        .LIMIT(OVERRIDE_CYCLES)
    ) u_override (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .run_in(~pins_sync[4]),
        .expired_out(override_expired)
    );

    // Restart the count on every state entry so each phase gets a full period
    assign seq_run = ((state == ST_WARN) || (state == ST_RESET)) && (state == prev_state);

    rcr_timer #(
        .LIMIT(TIMEOUT_CYCLES)
    ) u_seq_timeout (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .run_in(seq_run),
        .expired_out(seq_expired)
    );

    wire in_s0 = (sleep_state_in == `RCR_SLEEP_S0);
    wire in_s45 = (sleep_state_in == `RCR_SLEEP_S4) || (sleep_state_in == `RCR_SLEEP_S5);
    wire port_hit = (io_addr_in == `RCR_CTRL_PORT_ADDR);
    wire port_write = io_write_in && port_hit;
    wire cmd_reset = port_write &&
        ((io_wdata_in == `RCR_CMD_HOST_RESET) || (io_wdata_in == `RCR_CMD_PCYCLE_RESET));
    wire cmd_pcycle = io_wdata_in[`RCR_CTRL_PCYCLE_BIT];
    wire bit3 = ctrl_port[`RCR_CTRL_PCYCLE_BIT];
    wire wd_fault = pm_watchdog_timeout_in || mgmt_watchdog_timeout_in ||
        mgmt_uncorrectable_error_in;
    wire escalate = global_escalation_enable_in && in_s0;
    wire override_edge = override_expired && !override_prev;

    wire req_global =
        (cmd_reset && global_reset_select_in) ||
        (shutdown_cycle_in && global_reset_select_in) ||
        (in_s0 && (pins_fall[0] || pins_fall[1])) ||
        platform_power_good_stuck_in ||
        mgmt_global_reset_in ||
        (wd_fault && escalate);
    wire req_s5 =
        smbus_power_down_in ||
        pins_fall[3] || thermal_sensor_catastrophic_in ||
        override_edge ||
        mgmt_power_button_override_in ||
        (wd_fault && !escalate);
    wire req_pcycle =
        (cmd_reset && !global_reset_select_in && cmd_pcycle) ||
        (pins_fall[2] && bit3) ||
        (smbus_reset_req_in && smbus_reset_pcycle_in) ||
        (shutdown_cycle_in && !global_reset_select_in && bit3) ||
        mgmt_host_reset_pcycle_in ||
        mgmt_host_reset_power_down_in;
    wire req_host_raw =
        (cmd_reset && !global_reset_select_in && !cmd_pcycle) ||
        (pins_fall[2] && !bit3) ||
        (smbus_reset_req_in && !smbus_reset_pcycle_in) ||
        os_watchdog_second_expiry_in ||
        (shutdown_cycle_in && !global_reset_select_in && !bit3) ||
        mgmt_host_reset_in;
    wire req_host = req_host_raw && !in_s45;
    wire req_any = req_global || req_s5 || req_pcycle || req_host;
    wire [1:0] outcome = rcr_resolve(req_global, req_s5, req_pcycle);
    wire skip_warn = in_s45 && sleep_software_entered_in;

    assign busy_out = (state != ST_IDLE);

    always @* begin
        next_state = state;
        next_pcycle_flag = pcycle_flag;
        next_wake_hold_flag = wake_hold_flag;
        case (state)
            ST_IDLE: begin
                if (req_any) begin
                    case (outcome)
                        `RCR_OUT_GLOBAL: begin
                            next_state = ST_GLOBAL;
                        end
                        `RCR_OUT_S5: begin
                            next_state = ST_WAKE;
                            next_wake_hold_flag = 1'b0;
                        end
                        `RCR_OUT_PCYCLE: begin
                            next_pcycle_flag = 1'b1;
                            next_wake_hold_flag = mgmt_host_reset_power_down_in;
                            if (!skip_warn) begin
                                next_state = ST_WARN;
                            end else if (mgmt_host_reset_power_down_in) begin
                                // No handshake here, but the host still waits for the wake
                                next_state = ST_WAKE;
                            end else begin
                                next_state = ST_RESET;
                            end
                        end
                        default: begin
                            next_pcycle_flag = 1'b0;
                            next_wake_hold_flag = 1'b0;
                            next_state = ST_WARN;
                        end
                    endcase
                end
            end
            ST_WARN: begin
                if (seq_expired) begin
                    next_state = ST_GLOBAL;
                end else if (reset_ack_in) begin
                    next_state = wake_hold_flag ? ST_WAKE : ST_RESET;
                end
            end
            ST_RESET: begin
                if (seq_expired) begin
                    next_state = ST_GLOBAL;
                end else if (platform_reset_done_in) begin
                    next_state = ST_IDLE;
                end
            end
            ST_WAKE: begin
                if (wake_event_in) begin
                    // Deferred power-down reset completes only after the wake
                    next_state = wake_hold_flag ? ST_RESET : ST_IDLE;
                    next_wake_hold_flag = 1'b0;
                end
            end
            ST_GLOBAL: begin
                if (hold_count == `RCR_GLOBAL_HOLD_CYCLES) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // Global and S5 triggers preempt a sequence already under way
        if (state != ST_IDLE && state != ST_GLOBAL) begin
            if (req_global) begin
                next_state = ST_GLOBAL;
            end else if (req_s5 && !(state == ST_WAKE && !wake_hold_flag)) begin
                next_state = ST_WAKE;
                next_wake_hold_flag = 1'b0;
            end
        end
    end

    always @(posedge clk_in) begin
        if (reset_in) begin
            ctrl_port <= `RCR_CTRL_RESET_VAL;
            io_rdata_out <= 8'h00;
        end else begin
            if (port_write) begin
                // Reset-cpu bit is self-clearing, so only the sticky bits are kept
                ctrl_port <= io_wdata_in & `RCR_CTRL_STORE_MASK;
            end
            io_rdata_out <= (io_read_in && port_hit) ? ctrl_port : 8'h00;
        end
    end

    always @(posedge clk_in) begin
        if (reset_in) begin
            state <= ST_IDLE;
            prev_state <= ST_IDLE;
            pcycle_flag <= 1'b0;
            wake_hold_flag <= 1'b0;
            pins_prev <= `RCR_SYNC_INIT;
            override_prev <= 1'b0;
            hold_count <= 8'h00;
            platform_reset_n_out <= 1'b1;
            reset_warn_out <= 1'b0;
            power_cycle_out <= 1'b0;
            global_reset_out <= 1'b0;
            sleep_wells_off_out <= 1'b0;
            host_held_down_out <= 1'b0;
            reset_start_out <= 1'b0;
            reset_type_out <= `RCR_OUT_HOST;
        end else begin
            state <= next_state;
            prev_state <= state;
            pcycle_flag <= next_pcycle_flag;
            wake_hold_flag <= next_wake_hold_flag;
            pins_prev <= pins_sync;
            override_prev <= override_expired;
            hold_count <= (state == ST_GLOBAL) ? hold_count + 8'h01 : 8'h00;
            platform_reset_n_out <= (next_state == ST_IDLE) || (next_state == ST_WARN);
            reset_warn_out <= (next_state == ST_WARN);
            global_reset_out <= (next_state == ST_GLOBAL);
            power_cycle_out <= (next_state == ST_GLOBAL) ||
                ((next_state == ST_RESET) && next_pcycle_flag);
            sleep_wells_off_out <= (next_state == ST_WAKE);
            host_held_down_out <= (next_state == ST_WAKE);
            reset_start_out <= (next_state != state) && (state == ST_IDLE);
            if (next_state == ST_GLOBAL) begin
                reset_type_out <= `RCR_OUT_GLOBAL;
            end else if (next_state == ST_WAKE && !next_wake_hold_flag) begin
                reset_type_out <= `RCR_OUT_S5;
            end else if (state == ST_IDLE && next_state != ST_IDLE) begin
                reset_type_out <= next_pcycle_flag ? `RCR_OUT_PCYCLE : `RCR_OUT_HOST;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verification/rcr_platform_model.sv */
// Behavioural platform side: acknowledge, reset completion and wake
`timescale 1ns/1ps
`default_nettype none
module rcr_platform_model (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic warn_in,
    input wire logic rst_n_in,
    input wire logic wells_off_in,
    input wire logic [3:0] ack_dly_in,
    input wire logic [3:0] done_dly_in,
    input wire logic [3:0] wake_dly_in,
    input wire logic mute_ack_in,
    input wire logic mute_done_in,
    output logic ack_out,
    output logic done_out,
    output logic wake_out
);
    logic [3:0] wc, rc, kc;
    // Counts restart when their phase ends, so each delay applies per sequence
    always @(posedge clk_in) begin
        wc <= (reset_in || !warn_in) ? 4'h0 : wc + {3'h0, wc != 4'hf};
        rc <= (reset_in || rst_n_in) ? 4'h0 : rc + {3'h0, rc != 4'hf};
        kc <= (reset_in || !wells_off_in) ? 4'h0 : kc + {3'h0, kc != 4'hf};
    end
    // A muted answer leaves the resolver to its own timeout
    assign ack_out = warn_in && wc >= ack_dly_in && !mute_ack_in;
    assign done_out = !rst_n_in && !wells_off_in && rc >= done_dly_in && !mute_done_in;
    assign wake_out = wells_off_in && kc >= wake_dly_in;
endmodule
`default_nettype wire

/* File: verification/rcr_reset_cause_resolver_asserts.sv */
// Port-level checker for the reset cause resolver
`timescale 1ns/1ps
`default_nettype none
module rcr_chk #(
    parameter [27:0] TIMEOUT_CYCLES = 28'h000_0032
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic mgmt_host_reset_in,
    input wire logic mgmt_global_reset_in,
    input wire logic pm_watchdog_timeout_in,
    input wire logic os_watchdog_second_expiry_in,
    input wire logic global_escalation_enable_in,
    input wire logic [2:0] sleep_state_in,
    input wire logic reset_ack_in,
    input wire logic platform_reset_done_in,
    input wire logic wake_event_in,
    input wire logic platform_reset_n_out,
    input wire logic reset_warn_out,
    input wire logic power_cycle_out,
    input wire logic global_reset_out,
    input wire logic sleep_wells_off_out,
    input wire logic host_held_down_out,
    input wire logic reset_start_out,
    input wire logic [1:0] reset_type_out,
    input wire logic busy_out
);
    logic [27:0] warn_cnt;
    // Length of the current wait for an acknowledge
    always @(posedge clk_in) begin
        warn_cnt <= (reset_in || !reset_warn_out) ? 28'h000_0000 : warn_cnt + 28'h000_0001;
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    property p_os_wd;
        !busy_out && os_watchdog_second_expiry_in && sleep_state_in == 3'h0
            && !mgmt_global_reset_in |=> reset_start_out && reset_warn_out && reset_type_out == 2'h0;
    endproperty
    a_os_wd: assert property (p_os_wd) else $error("watchdog host reset missing");
    property p_drop;
        !busy_out && mgmt_host_reset_in && sleep_state_in[2] && !mgmt_global_reset_in |=> !busy_out;
    endproperty
    a_drop: assert property (p_drop) else $error("host reset taken while asleep");
    property p_mgmt_glob;
        !busy_out && mgmt_global_reset_in |=> global_reset_out && reset_type_out == 2'h3;
    endproperty
    a_mgmt_glob: assert property (p_mgmt_glob) else $error("global request not honoured");
    property p_pm_esc;
        !busy_out && pm_watchdog_timeout_in && global_escalation_enable_in
            && sleep_state_in == 3'h0 |=> global_reset_out;
    endproperty
    a_pm_esc: assert property (p_pm_esc) else $error("watchdog escalation missing");
    property p_pm_s5;
        !busy_out && pm_watchdog_timeout_in && !global_escalation_enable_in && !mgmt_global_reset_in
            |=> sleep_wells_off_out && reset_type_out == 2'h2;
    endproperty
    a_pm_s5: assert property (p_pm_s5) else $error("watchdog did not go to S5");
    property p_glob_now;
        $rose(global_reset_out) |-> power_cycle_out && !platform_reset_n_out && !reset_warn_out;
    endproperty
    a_glob_now: assert property (p_glob_now) else $error("global reset not immediate");
    property p_glob_hold;
        $rose(global_reset_out) |-> ##16 global_reset_out ##1 !global_reset_out;
    endproperty
    a_glob_hold: assert property (p_glob_hold) else $error("global reset hold wrong");
    property p_warn_end;
        $fell(reset_warn_out) |-> $past(reset_ack_in) || global_reset_out || sleep_wells_off_out;
    endproperty
    a_warn_end: assert property (p_warn_end) else $error("warning ended without cause");
    property p_warn_len;
        warn_cnt <= TIMEOUT_CYCLES + 28'h000_0002;
    endproperty
    a_warn_len: assert property (p_warn_len) else $error("warning wait not bounded");
    property p_rst_rise;
        $rose(platform_reset_n_out)
            |-> $past(platform_reset_done_in) || $past(global_reset_out) || $past(wake_event_in);
    endproperty
    a_rst_rise: assert property (p_rst_rise) else $error("reset released early");
    property p_wells;
        sleep_wells_off_out |-> host_held_down_out && !platform_reset_n_out;
    endproperty
    a_wells: assert property (p_wells) else $error("wells off without host hold");
    c_glob: cover property ($rose(global_reset_out));
    c_wells: cover property ($rose(sleep_wells_off_out));
    c_ack: cover property (reset_warn_out && reset_ack_in);
endmodule
`default_nettype wire

/* File: verification/test_rcr_reset_cause_resolver.sv */
// Random and corner-case bench for the reset cause resolver
`timescale 1ns/1ps
`default_nettype none
module test_rcr_reset_cause_resolver;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [15:0] io_addr_in = 16'h0000;
    logic io_write_in = 1'b0, io_read_in = 1'b0;
    logic [7:0] io_wdata_in = 8'h00, wd = 8'h06;
    logic global_reset_select_in = 1'b0, global_escalation_enable_in = 1'b0;
    logic system_reset_button_n_in = 1'b1, thermal_trip_n_in = 1'b1, power_button_n_in = 1'b1;
    logic platform_power_good_in = 1'b1, system_power_good_in = 1'b1;
    logic smbus_reset_pcycle_in = 1'b0, sleep_software_entered_in = 1'b0;
    logic [2:0] sleep_state_in = 3'h0;
    logic [13:0] trg = 14'h0000;
    logic [3:0] ack_dly = 4'h1, done_dly = 4'h2, wake_dly = 4'h3;
    logic mute_ack = 1'b0, mute_done = 1'b0, pgsel = 1'b0, bit3 = 1'b0;
    int err_count = 0, check_count = 0;
    wire mgmt_host_reset_in = trg[0], mgmt_host_reset_pcycle_in = trg[1];
    wire mgmt_power_button_override_in = trg[2], mgmt_global_reset_in = trg[3];
    wire mgmt_host_reset_power_down_in = trg[4], mgmt_watchdog_timeout_in = trg[5];
    wire mgmt_uncorrectable_error_in = trg[6], pm_watchdog_timeout_in = trg[7];
    wire smbus_reset_req_in = trg[8], smbus_power_down_in = trg[9];
    wire os_watchdog_second_expiry_in = trg[10], thermal_sensor_catastrophic_in = trg[11];
    wire shutdown_cycle_in = trg[12], platform_power_good_stuck_in = trg[13];
    wire [7:0] io_rdata_out;
    wire [1:0] reset_type_out;
    wire wake_event_in, reset_ack_in, platform_reset_done_in, platform_reset_n_out;
    wire reset_warn_out, power_cycle_out, global_reset_out, sleep_wells_off_out;
    wire host_held_down_out, reset_start_out, busy_out;

    always #10 clk_in = ~clk_in;

    // Short timeout and override counts keep the run brief
    rcr_reset_cause_resolver #(
        .TIMEOUT_CYCLES(28'h000_0032), .OVERRIDE_CYCLES(28'h000_0014)) DUT (.*);
    rcr_platform_model partner (.clk_in(clk_in), .reset_in(reset_in), .warn_in(reset_warn_out),
        .rst_n_in(platform_reset_n_out), .wells_off_in(sleep_wells_off_out), .ack_dly_in(ack_dly),
        .done_dly_in(done_dly), .wake_dly_in(wake_dly), .mute_ack_in(mute_ack),
        .mute_done_in(mute_done), .ack_out(reset_ack_in), .done_out(platform_reset_done_in),
        .wake_out(wake_event_in));

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task wrap_up;
        $display("checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic io(input logic wr, input logic [15:0] addr, input logic [7:0] data);
        @(negedge clk_in);
        io_addr_in = addr;
        io_wdata_in = data;
        io_write_in = wr;
        io_read_in = !wr;
        @(negedge clk_in);
        io_write_in = 1'b0;
        io_read_in = 1'b0;
    endtask

    // Outcome code per trigger: 0 host, 1 power cycle, 2 straight to S5, 3 global, -1 dropped
    function automatic int exp_of(input int i);
        int t;
        case (i)
            0, 10: t = 0;
            1, 4: t = 1;
            2, 9, 11, 16, 18: t = 2;
            3, 13, 17: t = 3;
            5, 6, 7: t = (global_escalation_enable_in && sleep_state_in == 3'h0) ? 3 : 2;
            8: t = smbus_reset_pcycle_in;
            12: t = global_reset_select_in ? 3 : bit3;
            15: t = bit3;
            default: t = global_reset_select_in ? 3 : wd[3];
        endcase
        if (t == 0 && sleep_state_in != 3'h0)
            t = -1;
        return t;
    endfunction

    task automatic run(input int i, input int j);
        int t, k;
        logic warnexp, glob, seen, esc;
        @(negedge clk_in);
        t = exp_of(i);
        if (j >= 0 && exp_of(j) > t)
            t = exp_of(j);
        warnexp = t < 2 && !(t == 1 && sleep_software_entered_in && sleep_state_in != 3'h0);
        if (i < 14)
            trg[i] = 1'b1;
        if (j >= 0)
            trg[j] = 1'b1;
        if (i == 14) begin
            io(1'b1, 16'h0cf9, wd);
            bit3 = wd[3];
        end
        if (i == 15)
            system_reset_button_n_in = 1'b0;
        if (i == 16)
            thermal_trip_n_in = 1'b0;
        if (i == 17 && pgsel)
            platform_power_good_in = 1'b0;
        if (i == 17 && !pgsel)
            system_power_good_in = 1'b0;
        if (i == 18)
            power_button_n_in = 1'b0;
        if (i != 14)
            @(negedge clk_in);
        trg = 14'h0000;
        seen = 1'b0;
        for (k = 0; k < 40 && !seen; k++) begin
            if (reset_start_out === 1'b1)
                seen = 1'b1;
            else
                @(negedge clk_in);
        end
        check("start", seen, t >= 0);
        glob = global_reset_out;
        if (seen) begin
            check("type", reset_type_out, t[1:0]);
            check("warn", reset_warn_out, warnexp);
            check("global", global_reset_out, t == 3);
            check("rst_n_seq", platform_reset_n_out, warnexp);
            check("pcycle", power_cycle_out, t == 3 || (t == 1 && !warnexp && i != 4));
            check("wells", sleep_wells_off_out, t == 2 || (t == 1 && !warnexp && i == 4));
        end
        system_reset_button_n_in = 1'b1;
        thermal_trip_n_in = 1'b1;
        power_button_n_in = 1'b1;
        for (k = 0; k < 400 && busy_out !== 1'b0; k++) begin
            @(negedge clk_in);
            glob = glob | global_reset_out;
        end
        check("idle", busy_out, 1'b0);
        esc = t == 3 || (t >= 0 && t < 2 && (mute_done || (mute_ack && warnexp)));
        check("escalated", glob, esc);
        platform_power_good_in = 1'b1;
        system_power_good_in = 1'b1;
        repeat (8) @(negedge clk_in);
    endtask

    initial begin
        int n, k;
        n = $urandom(32'h6581db78);
        repeat (10) @(negedge clk_in);
        reset_in = 1'b0;
        repeat (8) @(negedge clk_in);
        check("rst_n", platform_reset_n_out, 1'b1);
        io(1'b0, 16'h0cf9, 8'h00);
        check("ctrl_reset", io_rdata_out, 8'h00);
        io(1'b1, 16'h0cf9, 8'hff);
        io(1'b1, 16'h0cf8, 8'h00);
        io(1'b0, 16'h0cf9, 8'h00);
        check("ctrl", io_rdata_out, 8'h0a);
        io(1'b0, 16'h0cf8, 8'h00);
        check("unmapped", io_rdata_out, 8'h00);
        bit3 = 1'b1;
        run(3, 0);
        run(2, 1);
        global_reset_select_in = 1'b1;
        run(14, -1);
        global_reset_select_in = 1'b0;
        mute_ack = 1'b1;
        run(10, -1);
        mute_ack = 1'b0;
        mute_done = 1'b1;
        run(1, -1);
        for (n = 0; n < 80; n++) begin
            k = $urandom % 19;
            {global_reset_select_in, global_escalation_enable_in, sleep_software_entered_in,
                smbus_reset_pcycle_in, mute_ack, mute_done, pgsel} = 7'($urandom);
            {ack_dly, done_dly, wake_dly} = 12'($urandom);
            wd = ($urandom % 2) ? 8'h0e : 8'h06;
            case ($urandom % 3)
                0: sleep_state_in = 3'h0;
                1: sleep_state_in = 3'h4;
                default: sleep_state_in = 3'h5;
            endcase
            // Power-good drops only mean something while running
            if (k > 14)
                sleep_state_in = 3'h0;
            run(k, -1);
        end
        wrap_up;
    end

    initial begin
        #1_500_000;
        err_count++;
        wrap_up;
    end
endmodule
bind rcr_reset_cause_resolver rcr_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (.*);
`default_nettype wire
